// ===== logic/irqc_top.sv
// Interrupt enable/flag registers with low-voltage detector control.
// The core reaches the registers through a plain 8-bit register port;
// peripheral events arrive as one-cycle pulses on clk_i.
`timescale 1ns/1ns
module irqc_top
  import irqc_pkg::*;
#(
  parameter int LV_DELAY_CYC = LV_IRQ_DELAY_CYC
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Core register port.
  input  wire logic [3:0]  reg_sel_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  // External interrupt pins, asynchronous.
  input  wire logic [3:0]  ext_pin_i,
  // Peripheral event pulses.
  input  wire logic        adc_evt_i,
  input  wire logic [39:0] grp_evt_i,
  // Low-voltage analog side.
  input  wire logic        lv_cmp_i,
  output logic             lv_power_o,
  output logic [2:0]       lv_sel_o,
  output logic [15:0]      lv_level_mv_o,
  // Power modes and request to the core.
  input  wire logic        sleep_i,
  input  wire logic        idle_i,
  output logic             irq_req_o,
  output logic             wake_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the block.
  typedef struct packed {
    logic [15:0]     flag;      // Primary flags; bit 15 unused.
    logic [15:0]     en;        // Primary enables; bit 15 global.
    logic [9:0][7:0] grp;       // Group sub-source registers.
    logic [7:0]      edge_cfg;  // Edge select, two bits per pin.
    logic            lv_on;     // Detector-on control.
    logic [2:0]      lv_sel;    // Threshold select.
    logic [15:0]     lv_mv;     // Selected level in millivolts.
    logic [7:0]      rdata;     // Registered read data.
    logic            wake;      // Wake pulse from idle.
  } irqc_state_t;

  irqc_state_t s_reg;
  irqc_state_t s_next;

  logic [3:0] ext_pulse;  // Edge pulses per pin.
  logic       lv_det;     // Synchronised detect flag.
  logic       lv_set;     // Delayed low-voltage request pulse.
  logic [9:0] grp_hit;    // Group with an enabled pending sub-source.

  ////////////////////////////////////////////////////////////////////////////
  // Build the byte that a primary register reads back.
  function automatic logic [7:0] pri_read(input logic [7:0][4:0] row,
                                          input logic [15:0]     fl,
                                          input logic [15:0]     en);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 0; b < 8; b++) begin
      if (row[b] == MAP_NONE) begin
        r[b] = 1'b0;            // Unimplemented bit reads zero.
      end else if (row[b][4]) begin
        r[b] = fl[row[b][3:0]];
      end else begin
        r[b] = en[row[b][3:0]];
      end
    end
    return r;
  endfunction : pri_read

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the external pins.
  irqc_edge_det #(
    .N       (NUM_EXT)
  ) u_edge (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (ext_pin_i),
    .sel_i   (s_reg.edge_cfg),
    .pulse_o (ext_pulse)
  );

  // Detector is powered only when enabled and not sleeping.
  assign lv_power_o = s_reg.lv_on & ~sleep_i;

  // Delay from detect flag to request.
  irqc_lv_delay #(
    .DELAY_CYC (LV_DELAY_CYC)
  ) u_lv (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cmp_i     (lv_cmp_i),
    .active_i  (lv_power_o),
    .det_o     (lv_det),
    .set_o     (lv_set)
  );

  ////////////////////////////////////////////////////////////////////////////
  // A group flags when any implemented sub-source is pending and enabled.
  always_comb begin
    for (int g = 0; g < NUM_GRP; g++) begin
      grp_hit[g] = |(s_reg.grp[g][7:4] & s_reg.grp[g][3:0]
                     & GRP_MASK[g]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: software write first, then hardware sets, so a set that
  // lands in the same cycle as a clearing write is never lost.
  always_comb begin
    logic [1:0] pri_idx;
    logic [3:0] grp_idx;
    logic [4:0] m;
    pri_idx = 2'(reg_sel_i - REG_PRI0);
    grp_idx = 4'(reg_sel_i - REG_GRP0);
    m       = MAP_NONE;
    s_next  = s_reg;
    if (wr_i) begin
      if (reg_sel_i == REG_LV_CTL) begin
        // Detect flag is read-only; the write ignores bit 5.
        s_next.lv_on  = wdata_i[LV_ON_BIT];
        s_next.lv_sel = wdata_i[LV_SEL_LSB +: LV_SEL_W];
      end else if (reg_sel_i == REG_EDGE) begin
        s_next.edge_cfg = wdata_i;
      end else if (reg_sel_i < REG_GRP0) begin
        // Scatter the byte into flags and enables through the map.
        for (int b = 0; b < 8; b++) begin
          m = PRI_MAP[pri_idx][b];
          if (m == MAP_NONE) begin
            m = MAP_NONE;                   // Unimplemented bit.
          end else if (m[4]) begin
            s_next.flag[m[3:0]] = wdata_i[b];
          end else begin
            s_next.en[m[3:0]] = wdata_i[b];
          end
        end
      end else begin
        // Only implemented slots of a group hold a value.
        s_next.grp[grp_idx] = wdata_i & {GRP_MASK[grp_idx],
                                         GRP_MASK[grp_idx]};
      end
    end

    // Hardware sets of pin, converter and group flags.
    s_next.flag[NUM_EXT-1:0] = s_next.flag[NUM_EXT-1:0]
                               | ext_pulse;
    s_next.flag[SRC_ADC] = s_next.flag[SRC_ADC] | adc_evt_i;
    for (int g = 0; g < NUM_GRP; g++) begin
      s_next.grp[g][7:4] = s_next.grp[g][7:4]
                           | (grp_evt_i[g*NUM_SUB +: NUM_SUB]
                              & GRP_MASK[g]);
      s_next.flag[SRC_GRP0 + g] = s_next.flag[SRC_GRP0 + g]
                                  | grp_hit[g];
    end
    s_next.flag[SRC_GIE] = 1'b0;    // No flag sits in this slot.

    // The low-voltage request feeds group 3 only.
    s_next.grp[LV_GRP][GRP_FLAG_LSB + LV_SUB] =
      s_next.grp[LV_GRP][GRP_FLAG_LSB + LV_SUB] | lv_set;

    // Wake only when the flag truly rises; a preset flag blocks it.
    s_next.wake = lv_set & idle_i
                  & ~s_reg.grp[LV_GRP][GRP_FLAG_LSB + LV_SUB];

    // Level follows the select code.
    s_next.lv_mv = lv_level_mv(s_next.lv_sel);

    // Read data for the addressed register, one cycle later.
    if (reg_sel_i == REG_LV_CTL) begin
      s_next.rdata = {2'b00, lv_det, s_reg.lv_on, 1'b0,
                      s_reg.lv_sel};
    end else if (reg_sel_i == REG_EDGE) begin
      s_next.rdata = s_reg.edge_cfg;
    end else if (reg_sel_i < REG_GRP0) begin
      s_next.rdata = pri_read(PRI_MAP[pri_idx], s_reg.flag, s_reg.en);
    end else begin
      s_next.rdata = s_reg.grp[grp_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; all registers clear at reset except the level, which loads the value of select code 0.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg          <= '0;
      s_reg.lv_on    <= LV_CTL_RST[LV_ON_BIT];
      s_reg.lv_sel   <= LV_CTL_RST[LV_SEL_LSB +: LV_SEL_W];
      s_reg.lv_mv    <= lv_level_mv(LV_CTL_RST[LV_SEL_LSB +: LV_SEL_W]);
      s_reg.edge_cfg <= EDGE_RST;
      s_reg.flag     <= {2{PRI_RST}};
      s_reg.en       <= {2{PRI_RST}};
      s_reg.grp      <= {NUM_GRP{GRP_RST}};
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign rdata_o       = s_reg.rdata;
  assign lv_sel_o      = s_reg.lv_sel;
  assign lv_level_mv_o = s_reg.lv_mv;
  assign wake_o        = s_reg.wake;
  // Global enable gates every enabled, pending primary source.
  assign irq_req_o = s_reg.en[SRC_GIE]
                     & |(s_reg.flag[14:0] & s_reg.en[14:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sleep_power_off_a: assert property (sleep_i |-> !lv_power_o)
    else $error("detector powered during sleep");

  lv_on_write_a: assert property (
    (wr_i && reg_sel_i == REG_LV_CTL && !wdata_i[LV_ON_BIT])
      |=> !lv_power_o)
    else $error("detector still powered after off write");

  lv_top_level_a: assert property (
    (wr_i && reg_sel_i == REG_LV_CTL && wdata_i[2:0] == 3'h7)
      |=> lv_level_mv_o == 16'h0FA0)
    else $error("code 7 does not select 4.0 V");

  lv_flag_read_a: assert property (
    (reg_sel_i == REG_LV_CTL) |=> rdata_o[LV_DET_BIT] == $past(lv_det))
    else $error("detect flag read back wrong");

  // The request lands in its group slot first; the primary group flag
  // may only follow a cycle later, so it stays low on the next edge.
  lv_group_route_a: assert property (
    (lv_set && !wr_i && !grp_hit[LV_GRP]
     && !s_reg.flag[SRC_GRP0 + LV_GRP])
      |=> s_reg.grp[LV_GRP][GRP_FLAG_LSB + LV_SUB]
          && !s_reg.flag[SRC_GRP0 + LV_GRP])
    else $error("low-voltage request not in group 3");

  lv_wake_idle_a: assert property (
    (lv_set && idle_i && !s_reg.grp[LV_GRP][GRP_FLAG_LSB]) |=> wake_o)
    else $error("no wake on low-voltage request in idle");

  ext_flag_set_a: assert property (ext_pulse[0] |=>
    s_reg.flag[0] ##1 (s_reg.flag[0] || $past(wr_i)))
    else $error("pin 0 edge did not set its flag");

  grp_flag_set_a: assert property (grp_hit[3] |=>
    s_reg.flag[SRC_GRP0 + 3])
    else $error("group 3 flag not set by pending source");

  irq_global_a: assert property (!s_reg.en[SRC_GIE] |->
    !irq_req_o)
    else $error("request with global enable off");

  irq_pair_a: assert property (
    (s_reg.en[SRC_GIE] && s_reg.flag[SRC_ADC] && s_reg.en[SRC_ADC])
      |-> irq_req_o)
    else $error("enabled pending request not signalled");

  adc_flag_set_a: assert property (adc_evt_i |=>
    s_reg.flag[SRC_ADC])
    else $error("converter event did not set its flag");

  // A preset request flag is how software keeps idle undisturbed.
  lv_wake_mask_a: assert property (
    (lv_set && s_reg.grp[LV_GRP][GRP_FLAG_LSB + LV_SUB]) |=> !wake_o)
    else $error("wake raised although request flag was preset");

  lv_wake_c:  cover property (lv_set ##1 wake_o);
  ext_irq_c:  cover property (ext_pulse[2] ##[1:3] irq_req_o);
  grp_irq_c:  cover property (grp_hit[6] ##1 irq_req_o);
  adc_flag_c: cover property (adc_evt_i ##1 s_reg.flag[SRC_ADC]);

endmodule : irqc_top

// ===== pkg/irqc_pkg.sv
// Shared constants of the interrupt controller and low-voltage detect logic.
// Assumes an 8-bit special register port driven by the processor core.
package irqc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices on the core's register port.
  localparam logic [3:0] REG_LV_CTL = 4'h0;  // low_voltage_control
  localparam logic [3:0] REG_EDGE   = 4'h1;  // external_edge_config
  localparam logic [3:0] REG_PRI0   = 4'h2;  // primary_irq_ctrl_0..3
  localparam logic [3:0] REG_GRP0   = 4'h6;  // group_irq_ctrl_0..9

  // Reset values.
  localparam logic [7:0] LV_CTL_RST = 8'h00;
  localparam logic [7:0] EDGE_RST   = 8'h00;
  localparam logic [7:0] PRI_RST    = 8'h00;
  localparam logic [7:0] GRP_RST    = 8'h00;

  // Fields of low_voltage_control.
  localparam int LV_SEL_LSB = 0;
  localparam int LV_SEL_W   = 3;
  localparam int LV_ON_BIT  = 4;
  localparam int LV_DET_BIT = 5;

  // External edge selection codes, two bits per pin.
  localparam int         EDGE_W    = 2;
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Source numbering of the primary flag and enable vectors.
  localparam int NUM_EXT  = 4;
  localparam int NUM_GRP  = 10;
  localparam int NUM_SUB  = 4;
  localparam int SRC_GRP0 = 4;
  localparam int SRC_ADC  = 14;
  localparam int SRC_GIE  = 15;   // Enable slot only: global enable.
  localparam int GRP_FLAG_LSB = 4;
  localparam int LV_GRP   = 3;    // Low-voltage sits in group 3.
  localparam int LV_SUB   = 0;

  // Implemented sub-source slots of each group, group 9 first.
  typedef logic [9:0][3:0] irqc_mask_t;
  localparam irqc_mask_t GRP_MASK = '{4'h7, 4'h7, 4'h7, 4'h7, 4'h3,
                                      4'hF, 4'hF, 4'h3, 4'hF, 4'hF};

  // Primary bit map: {1=flag/0=enable, source}; 5'h1F is unused.
  typedef logic [3:0][7:0][4:0] irqc_map_t;
  localparam logic [4:0] MAP_NONE = 5'h1F;
  localparam irqc_map_t PRI_MAP = '{
    '{5'h19, 5'h18, 5'h13, 5'h12, 5'h09, 5'h08, 5'h03, 5'h02},
    '{5'h17, 5'h1D, 5'h1C, 5'h16, 5'h07, 5'h0D, 5'h0C, 5'h06},
    '{5'h1E, 5'h15, 5'h14, 5'h1B, 5'h0E, 5'h05, 5'h04, 5'h0B},
    '{5'h1F, 5'h1A, 5'h11, 5'h10, 5'h0A, 5'h01, 5'h00, 5'h0F}};

  // Timing.
  localparam int CLK_MHZ         = 25;
  localparam int LV_IRQ_DELAY_US = 120;
  localparam int LV_IRQ_DELAY_CYC = LV_IRQ_DELAY_US * CLK_MHZ;

  // Threshold level in millivolts for a select code.
  function automatic logic [15:0] lv_level_mv(input logic [2:0] code);
    unique case (code)
      3'h0: lv_level_mv = 16'h0708;  // 1.8 V
      3'h1: lv_level_mv = 16'h07D0;  // 2.0 V
      3'h2: lv_level_mv = 16'h0960;  // 2.4 V
      3'h3: lv_level_mv = 16'h0A8C;  // 2.7 V
      3'h4: lv_level_mv = 16'h0BB8;  // 3.0 V
      3'h5: lv_level_mv = 16'h0CE4;  // 3.3 V
      3'h6: lv_level_mv = 16'h0E10;  // 3.6 V
      3'h7: lv_level_mv = 16'h0FA0;  // 4.0 V
    endcase
  endfunction : lv_level_mv

endpackage : irqc_pkg

// ===== logic/irqc_edge_det.sv
// Pin synchronisers and edge detection for the external interrupt pins.
// Pins are asynchronous; sel_i comes from a register on the same clock.
`timescale 1ns/1ns
module irqc_edge_det
  import irqc_pkg::*;
#(
  parameter int N = NUM_EXT
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Pins and per-pin edge select.
  input  wire logic [N-1:0]      pin_i,
  input  wire logic [2*N-1:0]    sel_i,
  // One-cycle pulse per pin on a matching edge.
  output logic      [N-1:0]      pulse_o
);

  typedef struct packed {
    logic [N-1:0] sync1;  // First stage, read only by sync2.
    logic [N-1:0] sync2;  // Safe copy of the pin.
    logic [N-1:0] last;   // Previous safe value.
    logic [N-1:0] pulse;  // Registered edge pulse.
  } irqc_edge_t;

  irqc_edge_t s_reg;
  irqc_edge_t s_next;

  //////////////////////////////////////////////////////////////////////////
  // Edge match per pin against its two-bit code.
  always_comb begin
    logic rise;
    logic fall;
    rise = 1'b0;
    fall = 1'b0;
    s_next = s_reg;
    s_next.sync1 = pin_i;
    s_next.sync2 = s_reg.sync1;
    s_next.last  = s_reg.sync2;
    for (int i = 0; i < N; i++) begin
      rise = s_reg.sync2[i] & ~s_reg.last[i];
      fall = ~s_reg.sync2[i] & s_reg.last[i];
      unique case (sel_i[2*i +: 2])
        EDGE_OFF:  s_next.pulse[i] = 1'b0;
        EDGE_RISE: s_next.pulse[i] = rise;
        EDGE_FALL: s_next.pulse[i] = fall;
        EDGE_BOTH: s_next.pulse[i] = rise | fall;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pulse_o = s_reg.pulse;

  // A disabled pin never raises a pulse.
  edge_off_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_i[1:0] == EDGE_OFF) |=> !pulse_o[0])
    else $error("edge pulse while pin 0 disabled");

endmodule : irqc_edge_det

// ===== logic/irqc_lv_delay.sv
// Low-voltage comparator synchroniser and delayed interrupt request.
// cmp_i comes from the analog comparator, asynchronous to clk_i.
`timescale 1ns/1ns
module irqc_lv_delay
  import irqc_pkg::*;
#(
  parameter int DELAY_CYC = LV_IRQ_DELAY_CYC
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Comparator output and detector power state.
  input  wire logic cmp_i,
  input  wire logic active_i,
  // Detect level and one-cycle flag set pulse.
  output logic      det_o,
  output logic      set_o
);

  typedef struct packed {
    logic        sync1;  // First stage, read only by sync2.
    logic        sync2;  // Safe comparator level.
    logic        det;    // Detect flag, unfiltered.
    logic [11:0] cnt;    // Cycles the flag has been high.
    logic        fired;  // Request already raised this episode.
    logic        set;    // Set pulse toward the flag.
  } irqc_lvd_t;

  irqc_lvd_t s_reg;
  irqc_lvd_t s_next;

  //////////////////////////////////////////////////////////////////////////
  // No glitch filter: a supply hovering at the threshold may toggle det.
  always_comb begin
    s_next = s_reg;
    s_next.sync1 = cmp_i;
    s_next.sync2 = s_reg.sync1;
    s_next.det   = s_reg.sync2 & active_i;
    s_next.set   = 1'b0;
    if (!s_reg.det) begin
      // Any drop restarts the delay.
      s_next.cnt   = '0;
      s_next.fired = 1'b0;
    end else if (!s_reg.fired) begin
      if (s_reg.cnt == 12'(DELAY_CYC - 1)) begin
        s_next.set   = 1'b1;
        s_next.fired = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 12'h001;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign det_o = s_reg.det;
  assign set_o = s_reg.set;

  // The request only follows a full delay of detect held high.  The
  // detect flag may drop on the very edge that raises the pulse, so the
  // check looks at its value one cycle earlier.
  lv_delay_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    set_o |-> (s_reg.cnt == 12'(DELAY_CYC - 1)) && $past(det_o))
    else $error("low-voltage request before delay elapsed");

endmodule : irqc_lv_delay

// ===== testbench/irqc_core_model.sv
// Core model: drives the register port of the interrupt block.
// Assumes the block samples the port on the rising edge of clk_i.
`timescale 1ns/1ns
module irqc_core_model
  import irqc_pkg::*;
(
  // Clock.
  input  wire logic       clk_i,
  // Register port towards the block.
  output logic      [3:0] reg_sel_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Quiet bus at time zero.
  initial begin
    reg_sel_o = 4'h0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end

  // One write, strobe high for one edge; idle data is inverted so a
  // stale byte never looks like a fresh one.
  task automatic wr_reg(input logic [3:0] r, input logic [7:0] d);
    @(posedge clk_i) #1;
    reg_sel_o = r;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i) #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : wr_reg

  // Present a register index; the answer follows one edge later.
  task automatic sel_reg(input logic [3:0] r);
    @(posedge clk_i) #1;
    reg_sel_o = r;
  endtask : sel_reg

  // Let the detector settle before its flag is trusted.
  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask : settle

  // Preset the low-voltage flag, enable kept, so idle is not left.
  task automatic mask_lv_wake();
    wr_reg(REG_GRP0 + 4'h3, 8'h11);
  endtask : mask_lv_wake
endmodule : irqc_core_model

// ===== testbench/irq_ctrl_with_lv_detect_tb_top.sv
// Self-checking bench of the interrupt and low-voltage block.
// Assumes the core model above; a short low-voltage delay is used.
`timescale 1ns/1ns
module irq_ctrl_with_lv_detect_tb_top;
  import irqc_pkg::*;
  localparam int         DLY    = 8;  // Short delay keeps the run brief.
  localparam logic [3:0] R_PRI2 = REG_PRI0 + 4'h2;
  localparam logic [3:0] R_PRI3 = REG_PRI0 + 4'h3;
  localparam logic [3:0] R_G2   = REG_GRP0 + 4'h2;
  localparam logic [3:0] R_G3   = REG_GRP0 + 4'h3;
  logic        clk_i, rst_i, wr_i, lv_cmp_i, sleep_i, idle_i, chk;
  logic        adc_evt_i;        // Converter event pulse.
  logic [39:0] grp_evt_i, evt;   // Sub-source events and their copy.
  logic        lv_power_o, irq_req_o, wake_o;
  logic [3:0]  reg_sel_i, ext_pin_i, fr;
  logic [7:0]  wdata_i, rdata_o, fb;
  logic [2:0]  lv_sel_o;
  logic [15:0] lv_level_mv_o;
  logic [7:0]  exp_q[$];  // Expected read bytes, oldest first.
  logic [15:0] lvl[8] = '{16'h0708, 16'h07D0, 16'h0960, 16'h0A8C,
                          16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0};
  int          mismatches, n_compared, wakes, cycles, p;

  irqc_top #(.LV_DELAY_CYC(DLY)) dut_u (.clk_i, .rst_i, .reg_sel_i,
    .wr_i, .wdata_i, .rdata_o, .ext_pin_i, .adc_evt_i,
    .grp_evt_i, .lv_cmp_i, .lv_power_o, .lv_sel_o,
    .lv_level_mv_o, .sleep_i, .idle_i, .irq_req_o, .wake_o);
  irqc_core_model core_u (.clk_i(clk_i), .reg_sel_o(reg_sel_i),
    .wr_o(wr_i), .wdata_o(wdata_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // Note the expected byte, then flag the cycle where it must appear.
  task automatic rd(input logic [3:0] r, input logic [7:0] e);
    exp_q.push_back(e);
    core_u.sel_reg(r);
    @(posedge clk_i) #1;
    chk = 1'b1;
    @(posedge clk_i) #1;
    chk = 1'b0;
  endtask : rd

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // Watcher: takes the oldest note whenever read data is due; also
  // counts wake pulses and cuts a hang short.
  always @(posedge clk_i) begin
    cycles++;
    if (wake_o === 1'b1) wakes++;
    if (chk === 1'b1) check("rdata", {8'h00, exp_q.pop_front()},
                             {8'h00, rdata_o});
    if (cycles == 4000) begin
      mismatches++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h7a2d2d53));
    {rst_i, chk} = 2'b10;
    {ext_pin_i, lv_cmp_i, sleep_i, idle_i} = 7'h00;
    {adc_evt_i, grp_evt_i} = 41'h0;
    mismatches = 0;
    n_compared = 0;
    wakes = 0;
    cycles = 0;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    // Every register starts cleared.
    for (int r = 0; r < 16; r++) rd(4'(r), 8'h00);
    $display("test reset values done");
    // All eight threshold codes.
    for (int c = 0; c < 8; c++) begin
      core_u.wr_reg(REG_LV_CTL, 8'(c));
      @(posedge clk_i) #1;
      check("lv_sel", 16'(c), {13'h0, lv_sel_o});
      check("lv_level", lvl[c], lv_level_mv_o);
    end
    $display("test thresholds done");
    // Read-only and unused bits, sleep gating, request gating.
    core_u.wr_reg(REG_LV_CTL, 8'hFF);
    rd(REG_LV_CTL, 8'h17);
    check("lv_power", 16'h1, {15'h0, lv_power_o});
    sleep_i = 1'b1;
    @(posedge clk_i) #1;
    check("lv_power", 16'h0, {15'h0, lv_power_o});
    sleep_i = 1'b0;
    core_u.wr_reg(REG_PRI0, 8'hFF);
    rd(REG_PRI0, 8'h7F);
    check("irq_req", 16'h1, {15'h0, irq_req_o});
    core_u.wr_reg(REG_PRI0, 8'h7E);
    check("irq_req", 16'h0, {15'h0, irq_req_o});
    core_u.wr_reg(R_G2, 8'hFF);
    rd(R_G2, 8'h33);
    rd(R_PRI2, 8'h10);
    core_u.wr_reg(R_G2, 8'h00);
    core_u.wr_reg(R_PRI2, 8'h00);
    core_u.wr_reg(REG_PRI0, 8'h00);
    core_u.wr_reg(REG_LV_CTL, 8'h00);
    $display("test access kinds done");
    // Random sub-source events and a converter event, one cycle each.
    evt = 40'({$urandom, $urandom});
    grp_evt_i = evt;
    adc_evt_i = 1'b1;
    @(posedge clk_i) #1;
    {adc_evt_i, grp_evt_i} = 41'h0;
    rd(REG_PRI0 + 4'h1, 8'h80);
    for (int g = 0; g < NUM_GRP; g++) begin
      rd(REG_GRP0 + 4'(g), {evt[4*g +: 4] & GRP_MASK[g], 4'h0});
      core_u.wr_reg(REG_GRP0 + 4'(g), 8'h00);
    end
    core_u.wr_reg(REG_PRI0 + 4'h1, 8'h00);
    $display("test events done");
    // Each edge code on a random pin, rising then falling.
    for (int c = 0; c < 4; c++) begin
      p = $urandom % 4;
      fr = (p < 2) ? REG_PRI0 : R_PRI3;
      fb = 8'h10 << (p % 2);
      core_u.wr_reg(REG_EDGE, 8'(c << (2 * p)));
      ext_pin_i[p] = 1'b1;
      repeat (6) @(posedge clk_i);
      rd(fr, c[0] ? fb : 8'h00);
      core_u.wr_reg(fr, 8'h00);
      ext_pin_i[p] = 1'b0;
      repeat (6) @(posedge clk_i);
      rd(fr, c[1] ? fb : 8'h00);
      core_u.wr_reg(fr, 8'h00);
    end
    $display("test edges done");
    // Low supply in idle: delayed flag, one wake, then a masked wake.
    core_u.wr_reg(REG_LV_CTL, 8'h10);
    lv_cmp_i = 1'b1;
    idle_i = 1'b1;
    core_u.settle();
    rd(REG_LV_CTL, 8'h30);
    rd(R_G3, 8'h00);
    repeat (DLY + 4) @(posedge clk_i);
    rd(R_G3, 8'h10);
    check("wakes", 16'h1, 16'(wakes));
    core_u.wr_reg(R_G3, 8'h01);
    lv_cmp_i = 1'b0;
    repeat (4) @(posedge clk_i);
    core_u.mask_lv_wake();
    rd(R_PRI2, 8'h80);
    lv_cmp_i = 1'b1;
    repeat (DLY + 8) @(posedge clk_i);
    check("wakes", 16'h1, 16'(wakes));
    $display("test low voltage done");
    finish_test();
  end
endmodule : irq_ctrl_with_lv_detect_tb_top
